// ---- air_pkg.sv ----
// register map, field positions, reset values and timing figures of the audio input unit
`default_nettype none

package air_pkg;

    // register byte offsets
    localparam logic [7:0] AIR_REG_SETUP = 8'h00;   // port_setup_register
    localparam logic [7:0] AIR_REG_OSC_INC = 8'h04; // oversample phase increment
    localparam logic [7:0] AIR_REG_SCK_DIV = 8'h08; // bit clock divisor (master)
    localparam logic [7:0] AIR_REG_WS_LEN = 8'h0C;  // bit clocks per channel (master)
    localparam logic [7:0] AIR_REG_STATUS = 8'h10;  // live state and sticky overrun
    localparam logic [7:0] AIR_REG_DATA = 8'h14;    // sample word, read pops

    // setup register fields
    localparam int AIR_SETUP_ENABLE = 0;
    localparam int AIR_SETUP_MASTER = 1;
    localparam int AIR_SETUP_EDGE = 2;

    // status register fields
    localparam int AIR_STAT_AVAIL = 0;
    localparam int AIR_STAT_OVERRUN = 1;
    localparam int AIR_STAT_WS = 2;
    localparam int AIR_STAT_MASTER = 3;

    // sample word layout
    localparam int AIR_DATA_CHAN = 31;
    localparam int AIR_DATA_CNT_LSB = 24;
    localparam int AIR_DATA_CNT_W = 5;
    localparam int AIR_DATA_SAMPLE_W = 24;

    // reset values: slave, falling-edge sampling, disabled
    localparam logic [2:0] AIR_SETUP_RST = 3'h0;
    localparam logic [31:0] AIR_OSC_INC_RST = 32'h0;
    localparam logic [7:0] AIR_SCK_DIV_RST = 8'h08;
    localparam logic [7:0] AIR_WS_LEN_RST = 8'h20;
    localparam logic [7:0] AIR_WS_LEN_MIN = 8'h01;

    // timing figures
    localparam longint AIR_MCLK_HZ = 100_000_000;
    localparam longint AIR_OSC_MAX_HZ = 40_000_000;
    localparam longint AIR_SCK_MAX_HZ = 22_000_000;
    localparam int AIR_PHASE_W = 32;
    // largest increment that keeps the oversample clock at or below its ceiling
    localparam logic [31:0] AIR_OSC_INC_MAX =
        32'((AIR_OSC_MAX_HZ << AIR_PHASE_W) / AIR_MCLK_HZ);
    // smallest divisor that keeps a generated bit clock under its ceiling
    localparam logic [7:0] AIR_SCK_DIV_MIN =
        8'((AIR_OSC_MAX_HZ + AIR_SCK_MAX_HZ - 1) / AIR_SCK_MAX_HZ);

    // receiver states
    typedef enum logic {
        AIR_RX_HUNT,
        AIR_RX_WORD
    } air_rx_e;

endpackage : air_pkg

`default_nettype wire

// ---- air_fifo.sv ----
// sample fifo with a registered head word
`default_nettype none

module air_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    // pointer arithmetic needs a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("air_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];  // storage, no reset needed
    logic [AW-1:0] wp_r;              // write pointer
    logic [AW-1:0] rp_r;              // read pointer
    logic [AW:0] cnt_r;               // words held in storage
    logic [AW:0] cnt_nxt;
    logic head_valid_r;               // head register holds a word
    logic [WIDTH-1:0] head_r;         // head word, read data from a flop

    wire push = in_valid && in_ready;
    // refill the head when it is empty or being taken
    wire load = (!head_valid_r || out_ready) && (cnt_r != '0);

    // the head register counts toward the depth, so the buffer never holds more than DEPTH
    wire [AW:0] held = cnt_r + (AW + 1)'(head_valid_r);
    assign in_ready = (held != FULL);
    assign out_valid = head_valid_r;
    assign out_data = head_r;
    assign cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(load);

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers and head register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            head_valid_r <= 1'b0;
            head_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= load ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_nxt;
            head_valid_r <= load ? 1'b1 : (out_ready ? 1'b0 : head_valid_r);
            head_r <= load ? mem_r[rp_r] : head_r;
        end
    end

    // never more words than the storage can hold
    chk_fifo_bound: assert property (@(posedge mclk) disable iff (!resetn) cnt_r <= FULL)
        else $error("fifo count above depth");

endmodule : air_fifo

`default_nettype wire

// ---- air_receiver.sv ----
// serial audio input port: oversample clock, bit clock and word select, sample capture
`default_nettype none

module air_receiver import air_pkg::*; #(
    parameter int SAMPLE_W = 24,
    parameter int FIFO_DEPTH = 8
) (
    // core clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // oversample clock
    output logic oversample_clock_out,
    // serial bit clock pin
    input wire logic serial_bit_clock_in,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe_n,
    // serial data pin
    input wire logic serial_data_in,
    // word select pin
    input wire logic word_select_in,
    output logic word_select_out,
    output logic word_select_oe_n
);
    localparam logic [AIR_DATA_CNT_W-1:0] SW_CNT = AIR_DATA_CNT_W'(SAMPLE_W);

    // the word layout has room for 24 sample bits at most
    if (SAMPLE_W < 8 || SAMPLE_W > AIR_DATA_SAMPLE_W) begin : g_bad_width
        $error("air_receiver sample width must lie between 8 and 24");
    end

    // software-visible setup
    logic enable_r;            // receiver runs
    logic master_r;            // we own bit clock and word select
    logic edge_rise_r;         // 1 samples on rising bit clock edge
    logic [31:0] osc_inc_r;    // oversample phase increment
    logic [7:0] sck_div_r;     // oversample ticks per bit clock
    logic [7:0] ws_len_r;      // bit clocks per channel slot
    logic overrun_r;           // sticky: a word was dropped
    logic [31:0] rdata_r;      // read data, one cycle after the strobe

    // clock generation
    logic [31:0] phase_r;      // oversample accumulator
    logic [7:0] div_cnt_r;     // position inside one bit clock period
    logic sck_r;               // generated bit clock
    logic [7:0] ws_cnt_r;      // bit clocks into the current slot
    logic ws_r;                // generated word select

    // pin synchronisers: bit 0 clock, bit 1 word select, bit 2 data
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic sck_s3_r;            // previous synchronised clock, for edges

    // receiver
    air_rx_e state_r;
    logic ws_last_r;                      // word select at the previous sample edge
    logic [SAMPLE_W-1:0] shift_r;         // incoming bits, newest in bit 0
    logic [AIR_DATA_CNT_W-1:0] bits_r;    // bits kept in the current word
    logic pend_valid_r;                   // finished word waiting for the fifo
    logic [31:0] pend_data_r;

    // fifo handshake
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;

    // register decode
    wire wr_setup = reg_wr && (reg_addr == AIR_REG_SETUP);
    wire wr_osc = reg_wr && (reg_addr == AIR_REG_OSC_INC);
    wire wr_div = reg_wr && (reg_addr == AIR_REG_SCK_DIV);
    wire wr_wslen = reg_wr && (reg_addr == AIR_REG_WS_LEN);
    wire wr_status = reg_wr && (reg_addr == AIR_REG_STATUS);
    wire rd_data = reg_rd && (reg_addr == AIR_REG_DATA);

    // write values clamped to what the pins may carry
    wire [31:0] osc_inc_nxt = (reg_wdata > AIR_OSC_INC_MAX) ? AIR_OSC_INC_MAX : reg_wdata;
    wire [7:0] sck_div_nxt = (reg_wdata[7:0] < AIR_SCK_DIV_MIN) ?
                             AIR_SCK_DIV_MIN : reg_wdata[7:0];
    wire [7:0] ws_len_nxt = (reg_wdata[7:0] < AIR_WS_LEN_MIN) ? AIR_WS_LEN_MIN : reg_wdata[7:0];

    // setup and clock registers; reset leaves the port a timing slave
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            {edge_rise_r, master_r, enable_r} <= AIR_SETUP_RST;
            osc_inc_r <= AIR_OSC_INC_RST;
            sck_div_r <= AIR_SCK_DIV_RST;
            ws_len_r <= AIR_WS_LEN_RST;
        end else begin
            if (wr_setup) begin
                enable_r <= reg_wdata[AIR_SETUP_ENABLE];
                master_r <= reg_wdata[AIR_SETUP_MASTER];
                edge_rise_r <= reg_wdata[AIR_SETUP_EDGE];
            end
            osc_inc_r <= wr_osc ? osc_inc_nxt : osc_inc_r;
            sck_div_r <= wr_div ? sck_div_nxt : sck_div_r;
            ws_len_r <= wr_wslen ? ws_len_nxt : ws_len_r;
        end
    end

    // oversample clock: phase accumulator msb, 0.023 Hz steps at 100 MHz
    wire [31:0] phase_nxt = phase_r + osc_inc_r;
    wire osc_tick = !phase_r[31] && phase_nxt[31];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_nxt;
        end
    end
    assign oversample_clock_out = phase_r[31];

    // bit clock divider: period is sck_div_r oversample ticks
    wire gen_run = master_r && enable_r;
    wire div_wrap = (div_cnt_r >= sck_div_r - 8'h01);
    wire [7:0] div_cnt_nxt = div_wrap ? 8'h00 : div_cnt_r + 8'h01;
    wire sck_lvl_nxt = (div_cnt_nxt < (sck_div_r >> 1));
    wire sck_step = gen_run && osc_tick && (sck_lvl_nxt != sck_r);
    // word select moves on the edge that is not used for sampling
    wire ws_step = sck_step && (sck_lvl_nxt != edge_rise_r);
    wire ws_wrap = (ws_cnt_r >= ws_len_r - 8'h01);

    // generated bit clock and word select; unless master and enabled, the clock drops low on the next oversample tick and word select holds its level
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            div_cnt_r <= '0;
            sck_r <= 1'b0;
            ws_cnt_r <= '0;
            ws_r <= 1'b0;
        end else if (!gen_run) begin
            div_cnt_r <= '0;
            // stop on a tick so the last half period is never short;
            // with a zero increment the clock keeps its level
            sck_r <= osc_tick ? 1'b0 : sck_r;
            ws_cnt_r <= '0;
        end else if (osc_tick) begin
            div_cnt_r <= div_cnt_nxt;
            sck_r <= sck_lvl_nxt;
            if (ws_step) begin
                ws_cnt_r <= ws_wrap ? 8'h00 : ws_cnt_r + 8'h01;
                ws_r <= ws_wrap ? !ws_r : ws_r;
            end
        end
    end

    // pin directions: both timing pins are inputs unless we are master
    assign serial_bit_clock_out = sck_r;
    assign serial_bit_clock_oe_n = !master_r;
    assign word_select_out = ws_r;
    assign word_select_oe_n = !master_r;

    // in master mode our own clock and word select pass two flops as well,
    // so they stay aligned with the delayed data pin
    logic [1:0] own_s1_r;      // own word select and clock, first stage
    logic [1:0] own_s2_r;      // own word select and clock, second stage
    wire sck_now = master_r ? own_s2_r[0] : pin_s2_r[0];
    wire ws_now = master_r ? own_s2_r[1] : pin_s2_r[1];

    // two flops per pin before any logic looks at it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            own_s1_r <= '0;
            own_s2_r <= '0;
            sck_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= {serial_data_in, word_select_in, serial_bit_clock_in};
            pin_s2_r <= pin_s1_r;
            own_s1_r <= {ws_r, sck_r};
            own_s2_r <= own_s1_r;
            sck_s3_r <= sck_now;
        end
    end

    // sampling edge chosen by software; a 22 MHz clock still gives two
    // core cycles per half period, so no edge slips through unseen
    wire sck_rise = sck_now && !sck_s3_r;
    wire sck_fall = !sck_now && sck_s3_r;
    wire strobe = enable_r && (edge_rise_r ? sck_rise : sck_fall);
    wire sd_now = pin_s2_r[2];
    wire ws_turn = strobe && (ws_now != ws_last_r);

    // finished word: channel, bit count, sample left-justified in 24 bits
    wire [AIR_DATA_CNT_W-1:0] pad_w = SW_CNT - bits_r;
    wire [SAMPLE_W-1:0] just_w = shift_r << pad_w;
    wire [23:0] field_w = 24'({just_w, 24'h0} >> SAMPLE_W);
    wire [31:0] word_w = {ws_last_r, 2'h0, bits_r, field_w};
    wire fifo_take = pend_valid_r && fifo_in_ready;
    wire word_done = ws_turn && (state_r == AIR_RX_WORD);
    // a full fifo stalls the pending word; a word behind it is lost
    wire drop = word_done && pend_valid_r && !fifo_take;

    // receiver: any word length, any frame rate, framed by word select
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= AIR_RX_HUNT;
            ws_last_r <= 1'b0;
            shift_r <= '0;
            bits_r <= '0;
        end else if (!enable_r) begin
            state_r <= AIR_RX_HUNT;
            bits_r <= '0;
        end else if (strobe) begin
            ws_last_r <= ws_now;
            case (state_r)
                AIR_RX_HUNT: begin
                    // wait for a slot boundary so the first word is whole
                    if (ws_turn) begin
                        state_r <= AIR_RX_WORD;
                        shift_r <= SAMPLE_W'(sd_now);
                        bits_r <= AIR_DATA_CNT_W'(1);
                    end
                end
                AIR_RX_WORD: begin
                    if (ws_turn) begin
                        shift_r <= SAMPLE_W'(sd_now);
                        bits_r <= AIR_DATA_CNT_W'(1);
                    end else if (bits_r < SW_CNT) begin
                        // bits past the sample width are ignored
                        shift_r <= {shift_r[SAMPLE_W-2:0], sd_now};
                        bits_r <= bits_r + AIR_DATA_CNT_W'(1);
                    end
                end
                default: begin
                    state_r <= AIR_RX_HUNT;
                end
            endcase
        end
    end

    // pending word and sticky overrun; a new drop wins over the clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pend_valid_r <= 1'b0;
            pend_data_r <= '0;
            overrun_r <= 1'b0;
        end else begin
            if (word_done && !drop) begin
                pend_valid_r <= 1'b1;
                pend_data_r <= word_w;
            end else if (fifo_take) begin
                pend_valid_r <= 1'b0;
            end
            if (drop) begin
                overrun_r <= 1'b1;
            end else if (wr_status && reg_wdata[AIR_STAT_OVERRUN]) begin
                overrun_r <= 1'b0;
            end
        end
    end

    // eight-word buffer between capture and software
    air_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(pend_valid_r),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_r),
        .out_valid(fifo_out_valid),
        .out_ready(rd_data),
        .out_data(fifo_out_data)
    );

    // read selection; unmapped offsets read zero
    wire [31:0] rd_setup_w = {29'h0, edge_rise_r, master_r, enable_r};
    wire [31:0] rd_status_w = {28'h0, master_r, ws_last_r, overrun_r, fifo_out_valid};
    wire [31:0] rd_sel_w =
        (reg_addr == AIR_REG_SETUP) ? rd_setup_w :
        (reg_addr == AIR_REG_OSC_INC) ? osc_inc_r :
        (reg_addr == AIR_REG_SCK_DIV) ? {24'h0, sck_div_r} :
        (reg_addr == AIR_REG_WS_LEN) ? {24'h0, ws_len_r} :
        (reg_addr == AIR_REG_STATUS) ? rd_status_w :
        (reg_addr == AIR_REG_DATA && fifo_out_valid) ? fifo_out_data : 32'h0;

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_sel_w : 32'h0;
        end
    end
    assign reg_rdata = rdata_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_osc_inc_ceiling: assert property (osc_inc_r <= AIR_OSC_INC_MAX)
        else $error("oversample increment above ceiling");
    chk_slave_sck_input: assert property (!master_r |-> serial_bit_clock_oe_n)
        else $error("bit clock driven in slave mode");
    chk_edge_synced: assert property (strobe |-> sck_now != sck_s3_r)
        else $error("sample strobe without synchronised edge");
    chk_sck_from_tick: assert property ($changed(sck_r) && $past(gen_run)
                                        |-> $past(osc_tick))
        else $error("bit clock moved without oversample tick");
    chk_sck_half_min: assert property ($changed(sck_r) |=> $stable(sck_r))
        else $error("bit clock half period under two cycles");
    chk_word_captured: assert property (word_done |=> pend_valid_r || overrun_r)
        else $error("finished word neither kept nor flagged");
    chk_sample_edge: assert property (strobe |-> sck_now == edge_rise_r)
        else $error("sampled on the wrong bit clock edge");
    chk_slave_ws_input: assert property (!master_r |-> word_select_oe_n)
        else $error("word select driven in slave mode");
    chk_ws_opposite: assert property ($changed(ws_r) |-> $changed(sck_r)
                                      && sck_r != $past(edge_rise_r))
        else $error("word select moved off the opposite edge");
    chk_reset_slave: assert property ($rose(resetn) |-> !master_r && !enable_r)
        else $error("port not a slave after reset");
    chk_word_channel: assert property (word_done && !drop |=>
                                       pend_data_r[AIR_DATA_CHAN] == $past(ws_last_r))
        else $error("word channel not from word select");

    cov_word_to_fifo: cover property (fifo_take);
    cov_overrun: cover property ($rose(overrun_r));
    cov_master_ws: cover property (master_r && $changed(ws_r));
    cov_data_read: cover property (rd_data && fifo_out_valid);

endmodule : air_receiver

`default_nettype wire

// ---- air_adc_model.sv ----
// converter-side model of the serial audio link
`default_nettype none

module air_adc_model (
    // lines toward the port
    output logic sck_o,
    output logic ws_o,
    output logic sd_o,
    // resolved pin levels
    input wire logic sck_line,
    input wire logic ws_line
);
    timeunit 1ns;
    timeprecision 100ps;
    bit master_on = 1'b0; // port owns the timing
    bit rise = 1'b1; // port samples on rising edges
    int len = 4; // bits per master word
    logic [23:0] wl = 24'hA00000; // master word, channel high
    logic [23:0] wr = 24'h500000; // master word, channel low
    int errs = 0; // timing faults seen
    int idx = 0; // bit position in master word
    logic last_ws = 1'b0; // word select at last data change
    time last_t = 0; // last sampling edge seen

    // released lines start high, clock idle
    initial begin
        sck_o = 1'b0;
        ws_o = 1'b1;
        sd_o = 1'b1;
    end

    // stimulus pattern, only the top nb bits kept
    function automatic logic [23:0] pat(input logic [23:0] base, input int i, input int nb);
        return (base ^ 24'(i * 24'h3C5A69)) & ~(24'hFFFFFF >> nb);
    endfunction : pat

    // one bit, valid only around the sampling edge so a wrong edge reads garbage
    task automatic put_bit(input logic w, input logic d);
        #20;
        ws_o = w;
        sd_o = d;
        #20;
        sck_o = rise;
        #20;
        sd_o = ~d; // hold over
        #20;
        sck_o = ~rise; // 12.5 MHz bit clock
    endtask : put_bit

    // lead bit, n words on alternating channels, closing bit
    task automatic send(input int n, input int nb, input logic [23:0] base, input int stall);
        logic [23:0] w;
        #2; // step off the core clock edge
        sck_o = ~rise; // only a non-sampling transition
        put_bit(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            w = pat(base, i, nb);
            for (int b = 23; b > 23 - nb; b--) begin
                put_bit(~i[0], w[b]);
            end
            if (i == 0) begin
                #(stall); // clock stands still mid-frame
            end
        end
        put_bit(1'b0, 1'b0);
        ws_o = 1'b1; // released, shows the inverse
    endtask : send

    // master mode: next bit on each non-sampling edge, restart on word select change
    always @(sck_line) begin
        if (master_on && sck_line == ~rise) begin
            #1;
            if (ws_line != last_ws) begin
                idx = 0;
                last_ws = ws_line;
            end
            sd_o = (idx < len) ? (ws_line ? wl[23 - idx] : wr[23 - idx]) : 1'b0;
            idx++;
        end
        if (master_on && sck_line == rise) begin
            if ($time - last_t < 46) begin
                errs++;
            end
            last_t = $time;
        end
    end

    // master mode: word select must move on the non-sampling edge only
    always @(ws_line) begin
        #1;
        if (master_on && sck_line !== ~rise) begin
            errs++;
        end
    end
endmodule : air_adc_model

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the audio input unit
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import air_pkg::*;
    logic mclk, resetn, reg_wr, reg_rd; // core clock, reset, strobes
    logic [7:0] reg_addr; // register address
    logic [31:0] reg_wdata, reg_rdata, rd; // bus data and last read
    logic osc, sck_out, sck_oe_n, ws_out, ws_oe_n; // port outputs
    logic sck_o, ws_o, sd_o, sck_line, ws_line; // converter side and pins
    int mismatches = 0;
    int samples_checked = 0;
    int cnt; // edges or words counted

    // the port drives a pin while its enable is low
    assign sck_line = sck_oe_n ? sck_o : sck_out;
    assign ws_line = ws_oe_n ? ws_o : ws_out;

    air_receiver uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .oversample_clock_out(osc), .serial_bit_clock_in(sck_line),
        .serial_bit_clock_out(sck_out), .serial_bit_clock_oe_n(sck_oe_n),
        .serial_data_in(sd_o), .word_select_in(ws_line), .word_select_out(ws_out),
        .word_select_oe_n(ws_oe_n));
    air_adc_model adc (.sck_o(sck_o), .ws_o(ws_o), .sd_o(sd_o), .sck_line(sck_line),
        .ws_line(ws_line));

    // 100 MHz core clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // one read; data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : rd_reg

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd_reg(a);
        check(what, exp, rd);
    endtask : rchk

    // count rising edges of the oversample or bit clock
    task automatic rises(input bit w, input int cyc);
        logic p, s;
        #1;
        p = w ? sck_out : osc;
        cnt = 0;
        repeat (cyc) begin
            @(posedge mclk);
            #1;
            s = w ? sck_out : osc;
            cnt += int'(s && !p);
            p = s;
        end
    endtask : rises

    task automatic give_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task automatic t_reset;
        rchk(AIR_REG_SETUP, 32'h0, "setup");
        rchk(AIR_REG_SCK_DIV, 32'(AIR_SCK_DIV_RST), "divisor");
        rchk(AIR_REG_WS_LEN, 32'(AIR_WS_LEN_RST), "slot length");
        rchk(AIR_REG_STATUS, 32'h0, "status");
        rchk(8'h18, 32'h0, "unmapped");
        check("clock enable", 32'h1, 32'(sck_oe_n));
        check("ws enable", 32'h1, 32'(ws_oe_n));
    endtask : t_reset

    // ceiling clamp, then 25 MHz gives one rise every 4 cycles
    task automatic t_osc;
        reg_write(AIR_REG_OSC_INC, 32'hFFFFFFFF);
        rchk(AIR_REG_OSC_INC, 32'(AIR_OSC_INC_MAX), "increment ceiling");
        reg_write(AIR_REG_OSC_INC, 32'h40000000);
        repeat (2) @(posedge mclk);
        rises(1'b0, 400);
        check("oversample rises", 32'd100, 32'(cnt));
    endtask : t_osc

    // re-enable to hunt afresh, then send one frame
    task automatic t_slave(input bit r, input int n, input int nb, input logic [23:0] base,
            input int stall);
        reg_write(AIR_REG_SETUP, 32'h0);
        reg_write(AIR_REG_SETUP, {29'h0, r, 2'b01});
        adc.rise = r;
        adc.send(n, nb, base, stall);
        repeat (8) @(posedge mclk);
    endtask : t_slave

    // fifo keeps 8 words plus the one pending
    task automatic drain(input int n, input int nb, input logic [23:0] base);
        for (int i = 0; i < n && i < 9; i++) begin
            rchk(AIR_REG_DATA, {~i[0], 2'b00, 5'(nb), adc.pat(base, i, nb)}, "word");
        end
        rchk(AIR_REG_DATA, 32'h0, "empty read");
        rchk(AIR_REG_STATUS, 32'h0, "status drained");
    endtask : drain

    task automatic t_master;
        reg_write(AIR_REG_SETUP, 32'h0); // back to hunting, no partial word left
        reg_write(AIR_REG_OSC_INC, 32'h33333333);
        reg_write(AIR_REG_SCK_DIV, 32'h0);
        rchk(AIR_REG_SCK_DIV, 32'(AIR_SCK_DIV_MIN), "divisor floor");
        reg_write(AIR_REG_WS_LEN, 32'h4);
        adc.rise = 1'b1;
        reg_write(AIR_REG_SETUP, 32'h7);
        #1;
        check("clock driven", 32'h0, 32'(sck_oe_n));
        check("ws driven", 32'h0, 32'(ws_oe_n));
        repeat (4) @(posedge mclk);
        adc.master_on = 1'b1;
        rises(1'b1, 300);
        check("bit clock rate", 32'h1, 32'(cnt inside {[29:31]}));
        adc.master_on = 1'b0;
        reg_write(AIR_REG_SETUP, 32'h6);
        repeat (8) @(posedge mclk);
        cnt = 0;
        // first word follows the first rise of word select, channels alternate
        for (int i = 0; i < 9; i++) begin
            rd_reg(AIR_REG_STATUS);
            if (!rd[0]) begin
                break;
            end
            check("master status", 32'h9, rd & 32'hB);
            rchk(AIR_REG_DATA, i[0] ? 32'h04500000 : 32'h84A00000, "master word");
            cnt++;
        end
        check("master drained", 32'h8, rd & 32'hB);
        check("master words", 32'h1, 32'(cnt >= 4));
    endtask : t_master

    // hang guard, far beyond the expected run
    initial begin
        #150us;
        mismatches++;
        give_verdict();
    end

    initial begin
        resetn <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= 8'h00;
        reg_wdata <= 32'h0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_osc();
        t_slave(1'b0, 3, 24, 24'hC3A5F1, 0);
        drain(3, 24, 24'hC3A5F1);
        t_slave(1'b1, 3, 5, 24'h9E1234, 600);
        drain(3, 5, 24'h9E1234);
        t_slave(1'b1, 11, 4, 24'h5B0F00, 0);
        rchk(AIR_REG_STATUS, 32'h3, "overrun");
        reg_write(AIR_REG_STATUS, 32'h2);
        rchk(AIR_REG_STATUS, 32'h1, "overrun cleared");
        drain(11, 4, 24'h5B0F00);
        t_master();
        check("converter timing faults", 32'h0, 32'(adc.errs));
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
